// [logic/asrp_pkg.sv]
package asrp_pkg;

    localparam int          WORD_BITS      = 24;
    localparam int          DATA_BITS      = 22;
    localparam int          OVL_POS        = 23;
    localparam int          OVH_POS        = 22;
    localparam int          SIGN_POS       = 21;
    localparam int          CNT_W          = 5;
    localparam logic [4:0]  LAST_EDGE      = 5'h19;
    localparam logic [4:0]  WORD_EDGES     = 5'h18;
    localparam int          CONV_CNT_W     = 20;
    localparam int          CONV_TIME_US   = 1000;
    localparam int          MCLK_PERIOD_NS = 25;
    localparam int          CONV_CYCLES_DEF = (CONV_TIME_US * 1000) / MCLK_PERIOD_NS;

    // Coding limits of the result word
    localparam logic signed [23:0] POS_FS  = 24'sh1FFFFF;
    localparam logic signed [23:0] NEG_FS  = 24'shE00000;
    localparam logic signed [23:0] SAT_POS = 24'sh23D70A;
    localparam logic signed [23:0] SAT_NEG = 24'shDC28F6;

    localparam logic [23:0] WORD_RST = 24'h000000;
    localparam logic [3:0]  SYNC_RST = 4'h8;

    typedef enum logic [2:0] {
        ST_SHUT  = 3'h1,
        ST_CONV  = 3'h2,
        ST_SLEEP = 3'h4
    } asrp_state_e;

    // Modulator value to result word, saturating at the modulator limit
    function automatic logic [23:0] asrp_encode(input logic signed [23:0] v);
        logic signed [23:0] c;
        c = v;
        if (v > SAT_POS) begin
            c = SAT_POS;
        end else if (v < SAT_NEG) begin
            c = SAT_NEG;
        end
        return {(c < NEG_FS), (c > POS_FS), c[21:0]};
    endfunction

endpackage

// [logic/asrp_xfer_if.sv]
interface asrp_xfer_if;
    logic [23:0] word;
    logic        bit_val;
    logic        phase;
    logic        done;

    modport core (output word, input bit_val, input phase, input done);
    modport link (input word, output bit_val, output phase, output done);
endinterface

// [logic/asrp_sync.sv]
module asrp_sync #(
    parameter int             W       = 4,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= RST_VAL;
            q_out    <= RST_VAL;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule // asrp_sync

// [logic/asrp_shifter.sv]
module asrp_shifter
    import asrp_pkg::*;
(
    input  wire logic sck_in,
    input  wire logic cs_n_in,
    asrp_xfer_if.link xfer
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] idx;

    // After the 25th edge the next edge opens a new word (reads with select held low)
    assign cnt_next = (cnt_reg == LAST_EDGE) ? 5'h01 : cnt_reg + 5'h01;
    // R11 descending index: MSB first
    assign idx      = WORD_EDGES - cnt_next;

    ////////////////////////////////////////////////////////////////////
    // R6 frame gating: chip select high ends the frame
    // R16 bit order: one bit per falling edge
    always_ff @(negedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            cnt_reg      <= '0;
            xfer.bit_val <= 1'b0;
            xfer.phase   <= 1'b0;
            xfer.done    <= 1'b0;
        end else begin
            cnt_reg      <= cnt_next;
            xfer.bit_val <= (idx < 5'(WORD_BITS)) ? xfer.word[idx] : 1'b0;
            xfer.phase   <= (cnt_next != 5'h00) && (cnt_next <= WORD_EDGES);
            xfer.done    <= (cnt_next >= WORD_EDGES);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // R16 first bit: flag bit leads
    first_bit_a: assert property (@(negedge sck_in) disable iff (cs_n_in) // R16
        (cnt_reg == 5'h01) |-> (xfer.bit_val == xfer.word[OVL_POS]))
        else $error("first bit is not the top word bit");
    count_step_a: assert property (@(negedge sck_in) disable iff (cs_n_in) // R11
        ($past(xfer.phase) && xfer.phase) |-> (cnt_reg == $past(cnt_reg) + 5'h01))
        else $error("bit counter skipped a step");
    // R20 ready return: 25th edge ends data
    edge25_a: assert property (@(negedge sck_in) disable iff (cs_n_in) // R20
        (cnt_reg == LAST_EDGE) |-> (!xfer.phase && xfer.done))
        else $error("data phase still open after the 25th edge");
endmodule // asrp_shifter

// [logic/asrp_top.sv]
// Function
// R1 - Three wires: select, clock, data/ready
// R2 - Single or continuous mode; select starts
// R3 - Word is 24 bits, 22 data
// R4 - Select low: pin high busy, low ready
// R5 - Select high: pin released
// R6 - Host holds select low while clocking
// R7 - Bit 22 flags overflow high
// R8 - Bit 23 flags overflow low
// R9 - Host treats both flags set as error
// R10 - Bits 21..0 two's complement, 21 sign
// R11 - Magnitude bits sent MSB first
// R12 - In range both flags are zero
// R13 - No clamp at full-scale codes
// R14 - Overflow gives 23-bit code, flag sign
// R15 - Valid codes to 12 percent overrange
// R16 - Shift bit 23, 22, then 21..0
// R17 - Select fall in shutdown starts conversion
// R18 - Select rise in conversion: single mode
// R19 - Ready low: bits on falling clock edges
// R20 - After 25th edge pin shows ready
module asrp_top #(
    parameter int unsigned CONV_CYCLES = asrp_pkg::CONV_CYCLES_DEF
) (
    input  wire logic                                  MCLK_IN,
    input  wire logic                                  NRST_IN,
    input  wire logic                                  SCK_IN,
    input  wire logic                                  CS_N_IN,
    input  wire logic signed [asrp_pkg::WORD_BITS-1:0] ANALOG_CODE_IN,
    output logic                                       DOUT_RDY_OUT,
    output logic                                       DOUT_RDY_OE_N_OUT,
    output logic                                       CONV_ACTIVE_OUT,
    output logic                                       CONT_MODE_OUT
);
    import asrp_pkg::*;

    localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////
    // Link side and crossings

    asrp_xfer_if xfer_if ();

    // R1 link pins: select, clock, data/ready
    asrp_shifter u_link (
        .sck_in  (SCK_IN),
        .cs_n_in (CS_N_IN),
        .xfer    (xfer_if.link)
    );

    logic [3:0] sync_q;

    asrp_sync #(
        .W       (4),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clk_in   (MCLK_IN),
        .rst_n_in (NRST_IN),
        .d_in     ({CS_N_IN, xfer_if.phase, xfer_if.bit_val, xfer_if.done}),
        .q_out    (sync_q)
    );

    wire cs_low     = ~sync_q[3];
    wire xfer_busy  = sync_q[2];
    wire shift_bit  = sync_q[1];
    wire done_s     = sync_q[0];

    ////////////////////////////////////////////////////////////////////
    // State

    asrp_state_e             state_reg;
    asrp_state_e             state_next;
    logic [CONV_CNT_W-1:0]   cnt_reg;
    logic                    cs_low_d_reg;
    logic                    done_d_reg;
    logic                    single_reg;
    logic                    cont_reg;
    logic                    data_rdy_reg;
    logic                    pend_reg;
    logic [WORD_BITS-1:0]    pend_word_reg;
    logic [WORD_BITS-1:0]    out_word_reg;
    logic                    busy_latch_reg;
    logic                    pin_reg;
    logic                    oe_n_reg;
    logic                    conv_out_reg;

    wire cs_fall   = cs_low & ~cs_low_d_reg;
    wire cs_rise   = ~cs_low & cs_low_d_reg;
    wire done_rise = done_s & ~done_d_reg;
    wire in_conv   = (state_reg == ST_CONV);
    wire conv_end  = in_conv && (cnt_reg == CONV_LAST);

    // R10 R14 coding: two's complement, flag as sign
    // R15 saturation: codes held to modulator range
    wire [WORD_BITS-1:0] new_word = asrp_encode(ANALOG_CODE_IN);

    // R18 stop request: rising select during conversion
    wire stop_req  = single_reg | cs_rise;
    // Continuous mode aborted by a select rise loses its data
    wire keep_data = ~(cont_reg & stop_req);
    wire conv_load = conv_end & keep_data;
    // R19 word frozen while bits are shifting
    wire load_now  = (conv_load | pend_reg) & ~xfer_busy;
    wire [WORD_BITS-1:0] load_word = conv_load ? new_word : pend_word_reg;

    ////////////////////////////////////////////////////////////////////
    // Conversion sequencing

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            // R17 conversion start: falling select
            ST_SHUT: begin
                if (cs_fall) begin
                    state_next = ST_CONV;
                end
            end
            // R2 mode decision at end of conversion
            ST_CONV: begin
                if (conv_end && stop_req) begin
                    state_next = ST_SLEEP;
                end
            end
            // R18 no new conversion until word read
            ST_SLEEP: begin
                if (!data_rdy_reg) begin
                    state_next = ST_SHUT;
                end
            end
            default: begin
                state_next = ST_SHUT;
            end
        endcase
    end

    wire [CONV_CNT_W-1:0] cnt_next    = (in_conv && !conv_end) ? cnt_reg + 20'h00001 : '0;
    wire                  single_next = (state_reg == ST_SHUT) ? 1'b0 :
                                        (in_conv ? (single_reg | cs_rise) : single_reg);
    // R2 continuous mode: no select rise seen
    wire                  cont_next   = (conv_end && !stop_req) ? 1'b1 :
                                        ((state_next != ST_CONV) ? 1'b0 : cont_reg);
    wire                  pend_next   = (conv_load && xfer_busy) ? 1'b1 :
                                        (xfer_busy ? pend_reg : 1'b0);
    // New data wins over a clear in the same cycle
    wire                  rdy_next    = load_now ? 1'b1 :
                                        ((done_rise || (cs_rise && cont_reg)) ? 1'b0 :
                                         data_rdy_reg);
    // R4 ready latched on select fall in single mode
    wire                  latch_next  = cs_fall ? ~data_rdy_reg :
                                        (done_rise ? 1'b1 : busy_latch_reg);
    wire                  rdy_level   = cont_reg ? ~data_rdy_reg : busy_latch_reg;
    // R20 ready shown again once data phase ends
    wire                  pin_next    = xfer_busy ? shift_bit : rdy_level;

    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_reg    <= ST_SHUT;
            cnt_reg      <= '0;
            cs_low_d_reg <= 1'b0;
            done_d_reg   <= 1'b0;
            single_reg   <= 1'b0;
            cont_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            cs_low_d_reg <= cs_low;
            done_d_reg   <= done_s;
            single_reg   <= single_next;
            cont_reg     <= cont_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output word and pin

    // R3 word build: 24-bit result
    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            data_rdy_reg  <= 1'b0;
            pend_reg      <= 1'b0;
            pend_word_reg <= WORD_RST;
            out_word_reg  <= WORD_RST;
        end else begin
            data_rdy_reg  <= rdy_next;
            pend_reg      <= pend_next;
            pend_word_reg <= conv_end ? new_word : pend_word_reg;
            out_word_reg  <= load_now ? load_word : out_word_reg;
        end
    end

    assign xfer_if.word = out_word_reg;

    // R5 pin release: enable follows select
    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            busy_latch_reg <= 1'b1;
            pin_reg        <= 1'b1;
            oe_n_reg       <= 1'b1;
            conv_out_reg   <= 1'b0;
        end else begin
            busy_latch_reg <= latch_next;
            pin_reg        <= pin_next;
            oe_n_reg       <= ~cs_low;
            conv_out_reg   <= (state_next == ST_CONV);
        end
    end

    assign DOUT_RDY_OUT      = pin_reg;
    assign DOUT_RDY_OE_N_OUT = oe_n_reg;
    assign CONV_ACTIVE_OUT   = conv_out_reg;
    assign CONT_MODE_OUT     = cont_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking mclk_cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!NRST_IN);

    sequence direct_load_s;
        conv_load && !xfer_busy;
    endsequence

    // R5 released while deselected
    pin_release_a: assert property ( // R5
        !cs_low |=> DOUT_RDY_OE_N_OUT)
        else $error("pin driven while select is high");

    // R7 overflow high flag
    ovh_flag_a: assert property ( // R7
        direct_load_s ##0 (ANALOG_CODE_IN > POS_FS) && (ANALOG_CODE_IN <= SAT_POS)
        |=> xfer_if.word[OVH_POS] && !xfer_if.word[OVL_POS])
        else $error("overflow high flag missing");

    // R8 overflow low flag
    ovl_flag_a: assert property ( // R8
        direct_load_s ##0 (ANALOG_CODE_IN < NEG_FS) && (ANALOG_CODE_IN >= SAT_NEG)
        |=> xfer_if.word[OVL_POS] && !xfer_if.word[OVH_POS])
        else $error("overflow low flag missing");

    // R12 in-range flags clear
    in_range_a: assert property ( // R12
        direct_load_s ##0 (ANALOG_CODE_IN >= NEG_FS) && (ANALOG_CODE_IN <= POS_FS)
        |=> (xfer_if.word[OVL_POS:OVH_POS] == 2'h0)
            && (xfer_if.word[SIGN_POS:0] == $past(ANALOG_CODE_IN[SIGN_POS:0])))
        else $error("in-range code wrongly flagged or altered");

    // R13 full-scale not clamped
    no_clamp_a: assert property ( // R13
        direct_load_s ##0 (ANALOG_CODE_IN == 24'sh200000)
        |=> (xfer_if.word == 24'h600000))
        else $error("full-scale code clamped");

    // R15 modulator limit held
    saturate_a: assert property ( // R15
        direct_load_s ##0 (ANALOG_CODE_IN > SAT_POS)
        |=> (xfer_if.word == 24'h63D70A))
        else $error("overrange code not held at modulator limit");

    // R4 busy after fall
    busy_shown_a: assert property ( // R4
        cs_fall && !cont_reg && !data_rdy_reg && !xfer_busy && !cs_rise
        ##1 (cs_low && !xfer_busy) |=> DOUT_RDY_OUT)
        else $error("busy not shown after select fall");

    // R17 fall starts conversion
    conv_start_a: assert property ( // R17
        (state_reg == ST_SHUT) && cs_fall |=> in_conv && (cnt_reg == '0))
        else $error("select fall did not start a conversion");

    // R18 single mode stops
    single_stop_a: assert property ( // R18
        conv_end && single_reg |=> (state_reg == ST_SLEEP) ##1 (state_reg != ST_CONV))
        else $error("single mode did not stop after the conversion");

    // R18 unread word blocks
    hold_unread_a: assert property ( // R18
        (state_reg == ST_SLEEP) && data_rdy_reg && !done_rise |=> (state_reg == ST_SLEEP))
        else $error("conversion restarted with unread data");

    // R20 full read consumes
    read_clears_a: assert property ( // R20
        done_rise && !load_now |=> !data_rdy_reg)
        else $error("word still ready after full read");

    // R10 sign bit kept
    sign_bit_a: assert property ( // R10
        direct_load_s ##0 (ANALOG_CODE_IN >= NEG_FS) && (ANALOG_CODE_IN <= POS_FS)
        |=> (xfer_if.word[SIGN_POS] == $past(ANALOG_CODE_IN[WORD_BITS-1])))
        else $error("sign bit does not follow the input sign");

    // R14 overflow code value
    ovf_code_a: assert property ( // R14
        direct_load_s ##0 ((ANALOG_CODE_IN > POS_FS) || (ANALOG_CODE_IN < NEG_FS))
            && (ANALOG_CODE_IN <= SAT_POS) && (ANALOG_CODE_IN >= SAT_NEG)
        |=> ({xfer_if.word[OVL_POS], xfer_if.word[SIGN_POS:0]}
             == $past(ANALOG_CODE_IN[SIGN_POS+1:0])))
        else $error("overflow code is not a 23-bit two's complement value");

    // R8 flags never both set
    flags_excl_a: assert property ( // R8
        !(xfer_if.word[OVL_POS] && xfer_if.word[OVH_POS]))
        else $error("both overflow flags set in the output word");

    // R19 word frozen while shifting
    word_frozen_a: assert property ( // R19
        xfer_busy |=> $stable(xfer_if.word))
        else $error("output word changed during a data phase");

    // R19 data bit on pin
    pin_data_a: assert property ( // R19
        xfer_busy |=> (DOUT_RDY_OUT == $past(shift_bit)))
        else $error("pin does not carry the shifted bit");

    // R4 continuous ready level
    cont_ready_a: assert property ( // R4
        !xfer_busy && cont_reg |=> (DOUT_RDY_OUT == !$past(data_rdy_reg)))
        else $error("ready level wrong in continuous mode");

    // R4 pin driven while selected
    pin_driven_a: assert property ( // R4
        cs_low |=> !DOUT_RDY_OE_N_OUT)
        else $error("pin not driven while selected");

    // R2 continuous entry
    cont_entry_a: assert property ( // R2
        conv_end && !stop_req |=> cont_reg && in_conv)
        else $error("continuous mode not entered");

    // R2 select rise drops data
    cont_drop_a: assert property ( // R2
        cs_rise && cont_reg && !load_now |=> !data_rdy_reg)
        else $error("continuous data kept after select rise");

    // R17 conversion length
    conv_count_a: assert property ( // R17
        in_conv && !conv_end |=> in_conv && (cnt_reg == $past(cnt_reg) + 20'h00001))
        else $error("conversion counter skipped a step");

    // R18 single word kept
    single_keep_a: assert property ( // R18
        conv_end && single_reg && !cont_reg && !xfer_busy |=> data_rdy_reg)
        else $error("single conversion result not kept");

endmodule // asrp_top

// [verification/asrp_host_model.sv]
module asrp_host_model (
    input  wire logic pin_in,
    input  wire logic pin_oe_n_in,
    output logic      cs_n_out,
    output logic      sck_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic last_q;
    logic line;

    // three-wire link
    // Released line shows the inverse of the last driven level
    always @(pin_in or pin_oe_n_in) begin
        if (!pin_oe_n_in) last_q = pin_in;
    end
    assign line = pin_oe_n_in ? ~last_q : pin_in;

    initial begin
        cs_n_out = 1'b1;
        sck_out  = 1'b1;
        last_q   = 1'b0;
    end

    ////////////////////////////////////////////////////////////
    task automatic open_frame();
        #13;
        cs_n_out = 1'b0;
    endtask

    task automatic close_frame();
        #13;
        cs_n_out = 1'b1;
    endtask

    // Line is not trusted until the device has had time to drive it
    task automatic wait_ready(output logic ok);
        ok = 1'b0;
        #100;
        for (int n = 0; n < 400 && !ok; n++) begin
            #25;
            ok = (line === 1'b0);
        end
    endtask

    // falling edges shift, bit taken late in period
    task automatic read_word(output logic [23:0] w, output logic tail);
        for (int k = 23; k >= 0; k--) begin
            sck_out = 1'b0;
            #80;
            sck_out = 1'b1;
            #80;
            w[k] = line;
        end
        sck_out = 1'b0;
        #80;
        sck_out = 1'b1;
        #80;
        tail = line;
    endtask
endmodule // asrp_host_model

// [verification/adc_serial_readout_port_tb.sv]
module adc_serial_readout_port_tb
    import asrp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int CONV = 50;

    logic               mclk;
    logic               nrst;
    logic               sck;
    logic               cs_n;
    logic signed [23:0] code;
    logic               dout;
    logic               oe_n;
    logic               conv_act;
    logic               cont;
    int                 mismatches;
    int                 compares;
    int                 cycles;
    logic [23:0]        lfsr;
    logic [23:0]        w;
    logic               ok;
    logic               tail;
    logic signed [23:0] corners [10];

    asrp_top #(.CONV_CYCLES(CONV)) dut (
        .MCLK_IN           (mclk),
        .NRST_IN           (nrst),
        .SCK_IN            (sck),
        .CS_N_IN           (cs_n),
        .ANALOG_CODE_IN    (code),
        .DOUT_RDY_OUT      (dout),
        .DOUT_RDY_OE_N_OUT (oe_n),
        .CONV_ACTIVE_OUT   (conv_act),
        .CONT_MODE_OUT     (cont)
    );

    asrp_host_model host (
        .pin_in      (dout),
        .pin_oe_n_in (oe_n),
        .cs_n_out    (cs_n),
        .sck_out     (sck)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////
    function automatic logic [23:0] lfsr_next(input logic [23:0] s);
        return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
    endfunction

    function automatic logic [23:0] exp_word(input int v);
        int          c;
        logic [23:0] r;
        c = v > int'(SAT_POS) ? int'(SAT_POS) : (v < int'(SAT_NEG) ? int'(SAT_NEG) : v);
        r = c[23:0];
        r[23] = (c < int'(NEG_FS));
        r[22] = (c > int'(POS_FS));
        return r;
    endfunction

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (mismatches == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic wait_mclk(input int n);
        repeat (n) @(negedge mclk);
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic single_read(input logic signed [23:0] v);
        @(negedge mclk);
        code = v;
        host.open_frame();
        wait_mclk(6);
        check("busy_pin", {22'h0, oe_n, dout}, 24'h000001);
        check("conv_start", {23'h0, conv_act}, 24'h000001);
        host.close_frame();
        wait_mclk(6);
        check("released", {23'h0, oe_n}, 24'h000001);
        for (int n = 0; n < 200 && conv_act === 1'b1; n++) wait_mclk(1);
        check("single_mode", {22'h0, conv_act, cont}, 24'h000000);
        if (v == 0) begin
            host.open_frame();
            wait_mclk(8);
            host.close_frame();
            wait_mclk(8);
            check("unread_refused", {23'h0, conv_act}, 24'h000000);
        end
        host.open_frame();
        host.wait_ready(ok);
        check("ready", {23'h0, ok}, 24'h000001);
        host.read_word(w, tail);
        check("word", w, exp_word(v));
        check("tail", {23'h0, tail}, 24'h000001);
        check("both_flags", {23'h0, w[23] & w[22]}, 24'h000000);
        host.close_frame();
        wait_mclk(6);
    endtask

    initial begin
        nrst = 1'b0;
        code = 24'sh000000;
        mismatches = 0;
        compares = 0;
        cycles = 0;
        lfsr = 24'h00002C;
        corners = '{24'sh000000, 24'sh000001, 24'shFFFFFF, 24'sh1FFFFF, 24'sh200000,
                    24'shE00000, 24'shDFFFFF, 24'sh23D70B, 24'shC00000, 24'sh3FFFFF};
        repeat (16) @(negedge mclk);
        check("reset", {20'h0, oe_n, dout, conv_act, cont}, 24'h00000C);
        nrst = 1'b1;
        wait_mclk(4);
        for (int i = 0; i < 10; i++) single_read(corners[i]);
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            single_read({lfsr[22], lfsr[22:0]});
        end
        @(negedge mclk);
        code = 24'sh0ABCDE;
        host.open_frame();
        host.wait_ready(ok);
        check("cont_mode", {22'h0, ok, cont}, 24'h000003);
        host.read_word(w, tail);
        check("cont_word", w, exp_word(24'sh0ABCDE));
        @(negedge mclk);
        code = 24'shF12345;
        wait_mclk(150);
        host.wait_ready(ok);
        host.read_word(w, tail);
        check("cont_latest", w, exp_word(24'shF12345));
        host.close_frame();
        wait_mclk(60);
        check("cont_stop", {21'h0, oe_n, cont, conv_act}, 24'h000004);
        complete_run();
    end
endmodule // adc_serial_readout_port_tb
